//--- core/fieldbus_process_image_slave.v
`timescale 1ns/1ps
`include "fieldbus_image_regs.vh"

module fieldbus_process_image_slave #(
    parameter REFRESH_CYCLES = `REFRESH_CYCLES
) (
    // clock and reset
    input wire clock_in,
    input wire arst_n_in,
    // rotary selectors
    input wire [3:0] address_tens_in,
    input wire [3:0] address_ones_in,
    input wire [3:0] bit_rate_selector_in,
    // controller state
    input wire [23:0] fieldbus_outputs_in,
    input wire output_fault_lamp_in,
    input wire input_fault_lamp_in,
    input wire general_fault_lamp_in,
    input wire diagnostic_lamp_in,
    input wire run_lamp_in,
    input wire link_ok_in,
    input wire [63:0] input_states_in,
    // config table write port
    input wire config_write_in,
    input wire [6:0] config_index_in,
    input wire [7:0] config_data_in,
    // inbound area from master, byte-lane strobes
    input wire [159:0] inbound_data_in,
    input wire [19:0] inbound_strobe_in,
    // outbound read port
    input wire [4:0] read_byte_in,
    input wire [1:0] read_width_in,
    output reg [31:0] read_data_out,
    // settings and image
    output wire [6:0] station_address_out,
    output wire [3:0] bit_rate_code_out,
    output wire bit_rate_valid_out,
    output reg [159:0] outbound_image_out,
    output reg [159:0] inbound_image_out,
    output reg refresh_pulse_out,
    output wire [10:0] tpdo1_id_out,
    output wire [10:0] tpdo2_id_out,
    output wire [10:0] tpdo3_id_out,
    output wire [10:0] rpdo1_id_out,
    output wire [10:0] rpdo2_id_out,
    output wire [10:0] rpdo3_id_out,
    output wire [15:0] outbound_object_out,
    output wire [15:0] inbound_object_out
);

    localparam [1:0] WIDTH_BYTE = 2'd0;
    localparam [1:0] WIDTH_WORD = 2'd1;
    localparam [1:0] WIDTH_DWORD = 2'd2;

    localparam ST_IDLE = 1'b0;
    localparam ST_BUILD = 1'b1;

    reg state;
    reg [31:0] refresh_count;
    reg [7:0] config_mem [0:(`CONFIG_SEGMENTS * `SEGMENT_BYTES) - 1];
    reg [7:0] answer_table;
    reg [7:0] answer_segment;
    reg [`SEGMENT_BITS-1:0] answer_data;
    reg [7:0] next_segment;
    reg [`SEGMENT_BITS-1:0] next_data;
    integer i;
    integer j;

    selector_decode selectors (
        .clock_in(clock_in),
        .arst_n_in(arst_n_in),
        .address_tens_in(address_tens_in),
        .address_ones_in(address_ones_in),
        .bit_rate_selector_in(bit_rate_selector_in),
        .station_address_out(station_address_out),
        .bit_rate_code_out(bit_rate_code_out),
        .bit_rate_valid_out(bit_rate_valid_out)
    );

    function [10:0] cob_id;
        input [10:0] base;
        input [6:0] node;
        begin
            cob_id = base + {4'h0, node};
        end
    endfunction

    function [7:0] area_byte;
        input [159:0] area;
        input [5:0] index;
        begin
            area_byte = (index < 6'd20) ? area[index * 8 +: 8] : 8'h00;
        end
    endfunction

    // six bits so a wide read near byte 31 cannot wrap to byte 0
    function [5:0] lane_index;
        input [4:0] first;
        input [1:0] lane;
        begin
            lane_index = {1'b0, first} + {4'h0, lane};
        end
    endfunction

    // byte 3 layout, also served as table 5 segment 0
    function [7:0] status_byte;
        input output_fault_lamp;
        input input_fault_lamp;
        input fault;
        input diagnostic_lamp;
        input run;
        input link;
        begin
            status_byte = {2'b00, link, run, diagnostic_lamp, fault, input_fault_lamp, output_fault_lamp};
        end
    endfunction

    assign tpdo1_id_out = cob_id(`COB_TPDO1, station_address_out);
    assign tpdo2_id_out = cob_id(`COB_TPDO2, station_address_out);
    assign tpdo3_id_out = cob_id(`COB_TPDO3, station_address_out);
    assign rpdo1_id_out = cob_id(`COB_RPDO1, station_address_out);
    assign rpdo2_id_out = cob_id(`COB_RPDO2, station_address_out);
    assign rpdo3_id_out = cob_id(`COB_RPDO3, station_address_out);
    assign outbound_object_out = `OBJECT_OUTBOUND;
    assign inbound_object_out = `OBJECT_INBOUND;

    wire [7:0] req_table = inbound_image_out[`BYTE_TABLE*8 +: 8];
    wire [7:0] req_segment = inbound_image_out[`BYTE_SEGMENT*8 +: 8];
    wire refresh_due = (refresh_count >= REFRESH_CYCLES - 1);
    wire [5:0] lane0 = lane_index(read_byte_in, 2'd0);
    wire [5:0] lane1 = lane_index(read_byte_in, 2'd1);
    wire [5:0] lane2 = lane_index(read_byte_in, 2'd2);
    wire [5:0] lane3 = lane_index(read_byte_in, 2'd3);

    // segment lookup; any table/segment pair each refresh
    always @* begin
        next_segment = req_segment;
        next_data = {`SEGMENT_BITS{1'b0}};
        case (req_table)
            `TABLE_CONFIG: begin
                if (req_segment < `CONFIG_SEGMENTS) begin
                    for (i = 0; i < `SEGMENT_BYTES; i = i + 1) begin
                        next_data[i*8 +: 8] =
                            config_mem[req_segment[2:0] * 13 + i];
                    end
                end else begin
                    next_segment = `SEGMENT_INVALID;
                end
            end
            `TABLE_INPUTS: begin
                if (req_segment == 8'h00) begin
                    next_data[63:0] = input_states_in;
                end else begin
                    next_segment = `SEGMENT_INVALID;
                end
            end
            `TABLE_OUTPUTS: begin
                if (req_segment == 8'h00) begin
                    next_data[23:0] = fieldbus_outputs_in;
                end else begin
                    next_segment = `SEGMENT_INVALID;
                end
            end
            `TABLE_LAMPS: begin
                if (req_segment == 8'h00) begin
                    next_data[7:0] = status_byte(output_fault_lamp_in,
                        input_fault_lamp_in, general_fault_lamp_in,
                        diagnostic_lamp_in, run_lamp_in, link_ok_in);
                end else begin
                    next_segment = `SEGMENT_INVALID;
                end
            end
            default: begin
                // reserved and unknown tables have no segments
                next_segment = `SEGMENT_INVALID;
            end
        endcase
    end

    // config memory has no reset; software loads it after power-up
    always @(posedge clock_in) begin
        if (config_write_in &&
            config_index_in < `CONFIG_SEGMENTS * `SEGMENT_BYTES) begin
            config_mem[config_index_in] <= config_data_in;
        end
    end

    // inbound bytes land per lane, so byte/word/dword writes all work
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            inbound_image_out <= 160'h0;
        end else begin
            for (j = 0; j < `AREA_BYTES; j = j + 1) begin
                if (inbound_strobe_in[j]) begin
                    inbound_image_out[j*8 +: 8] <=
                        inbound_data_in[j*8 +: 8];
                end
            end
        end
    end

    // refresh timer and two-step image build
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            state <= ST_IDLE;
            refresh_count <= 32'h0000_0000;
            refresh_pulse_out <= 1'b0;
            answer_table <= 8'h00;
            answer_segment <= 8'h00;
            answer_data <= {`SEGMENT_BITS{1'b0}};
            outbound_image_out <= 160'h0;
        end else begin
            refresh_pulse_out <= 1'b0;
            case (state)
                ST_IDLE: begin
                    if (refresh_due) begin
                        refresh_count <= 32'h0000_0000;
                        answer_table <= req_table;
                        answer_segment <= next_segment;
                        answer_data <= next_data;
                        state <= ST_BUILD;
                    end else begin
                        refresh_count <= refresh_count + 32'h0000_0001;
                    end
                end
                ST_BUILD: begin
                    refresh_count <= refresh_count + 32'h0000_0001;
                    outbound_image_out[23:0] <= fieldbus_outputs_in;
                    outbound_image_out[31:24] <= status_byte(
                        output_fault_lamp_in, input_fault_lamp_in,
                        general_fault_lamp_in, diagnostic_lamp_in,
                        run_lamp_in, link_ok_in);
                    outbound_image_out[39:32] <= answer_table;
                    outbound_image_out[47:40] <= answer_segment;
                    outbound_image_out[151:48] <= answer_data;
                    outbound_image_out[159:152] <= 8'h00;
                    refresh_pulse_out <= 1'b1;
                    state <= ST_IDLE;
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // read port; little-endian lanes, bytes past 19 read zero
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            read_data_out <= 32'h0000_0000;
        end else begin
            case (read_width_in)
                WIDTH_BYTE: read_data_out <= {24'h00_0000,
                    area_byte(outbound_image_out, lane0)};
                WIDTH_WORD: read_data_out <= {16'h0000,
                    area_byte(outbound_image_out, lane1),
                    area_byte(outbound_image_out, lane0)};
                WIDTH_DWORD: read_data_out <= {
                    area_byte(outbound_image_out, lane3),
                    area_byte(outbound_image_out, lane2),
                    area_byte(outbound_image_out, lane1),
                    area_byte(outbound_image_out, lane0)};
                default: read_data_out <= 32'h0000_0000;
            endcase
        end
    end

endmodule // fieldbus_process_image_slave

//--- include/fieldbus_image_regs.vh
`ifndef FIELDBUS_IMAGE_REGS_VH
`define FIELDBUS_IMAGE_REGS_VH

// exchange area
`define AREA_BYTES 20
`define AREA_BITS 160
`define BYTE_STATUS 3
`define BYTE_TABLE 4
`define BYTE_SEGMENT 5
`define BYTE_DATA_FIRST 6
`define SEGMENT_BYTES 13
`define SEGMENT_BITS 104
`define SEGMENT_INVALID 8'hff

// status byte fields
`define STATUS_OUTPUT_FAULT 0
`define STATUS_INPUT_FAULT 1
`define STATUS_GENERAL_FAULT 2
`define STATUS_DIAGNOSTIC 3
`define STATUS_RUN 4
`define STATUS_LINK_OK 5

// tables
`define TABLE_CONFIG 8'h01
`define TABLE_INPUTS 8'h03
`define TABLE_OUTPUTS 8'h04
`define TABLE_LAMPS 8'h05
`define CONFIG_SEGMENTS 6

// object dictionary and pdo identifier bases
`define OBJECT_OUTBOUND 16'h2000
`define OBJECT_INBOUND 16'h2100
`define COB_TPDO1 11'h180
`define COB_TPDO2 11'h280
`define COB_TPDO3 11'h1c0
`define COB_RPDO1 11'h200
`define COB_RPDO2 11'h300
`define COB_RPDO3 11'h240

// bit rate codes
`define RATE_NONE 4'h0
`define RATE_10K 4'h1
`define RATE_20K 4'h2
`define RATE_50K 4'h3
`define RATE_125K 4'h4
`define RATE_250K 4'h5
`define RATE_500K 4'h6
`define RATE_800K 4'h7
`define RATE_1M 4'h8

// refresh timing
`define REFRESH_MS 15
`define CLOCK_MHZ 200
`define REFRESH_CYCLES (`REFRESH_MS * 1000 * `CLOCK_MHZ)

`endif

//--- core/selector_decode.v
`timescale 1ns/1ps
`include "fieldbus_image_regs.vh"

module selector_decode (
    // clock and reset
    input wire clock_in,
    input wire arst_n_in,
    // rotary selectors
    input wire [3:0] address_tens_in,
    input wire [3:0] address_ones_in,
    input wire [3:0] bit_rate_selector_in,
    // decoded settings
    output reg [6:0] station_address_out,
    output reg [3:0] bit_rate_code_out,
    output reg bit_rate_valid_out
);

    function [6:0] bcd_to_bin;
        input [3:0] tens;
        input [3:0] ones;
        begin
            // tens * 8 + tens * 2 + ones, all in seven bits
            bcd_to_bin = {tens, 3'b000} + {2'b00, tens, 1'b0}
                + {3'b000, ones};
        end
    endfunction

    // digits above 9 clamp to 9 so address stays within 0..99
    wire [3:0] tens_safe = (address_tens_in > 4'h9) ? 4'h9 : address_tens_in;
    wire [3:0] ones_safe = (address_ones_in > 4'h9) ? 4'h9 : address_ones_in;

    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            station_address_out <= 7'h00;
            bit_rate_code_out <= `RATE_NONE;
            bit_rate_valid_out <= 1'b0;
        end else begin
            station_address_out <= bcd_to_bin(tens_safe, ones_safe);
            if (bit_rate_selector_in >= `RATE_10K &&
                bit_rate_selector_in <= `RATE_1M) begin
                bit_rate_code_out <= bit_rate_selector_in;
                bit_rate_valid_out <= 1'b1;
            end else begin
                bit_rate_code_out <= `RATE_NONE;
                bit_rate_valid_out <= 1'b0;
            end
        end
    end

endmodule // selector_decode

//--- tb/fieldbus_image_props.sv
`timescale 1ns/1ps
module fieldbus_image_props #(
    parameter REFRESH_CYCLES = 20
) (
    // clock and reset
    input wire clock_in,
    input wire arst_n_in,
    // selectors and state
    input wire [3:0] address_tens_in,
    input wire [3:0] address_ones_in,
    input wire [3:0] bit_rate_selector_in,
    input wire [23:0] fieldbus_outputs_in,
    input wire link_ok_in,
    input wire [4:0] read_byte_in,
    input wire [1:0] read_width_in,
    // results
    input wire [31:0] read_data_out,
    input wire [6:0] station_address_out,
    input wire [3:0] bit_rate_code_out,
    input wire bit_rate_valid_out,
    input wire [159:0] outbound_image_out,
    input wire [159:0] inbound_image_out,
    input wire refresh_pulse_out,
    input wire [10:0] tpdo1_id_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!arst_n_in);
    logic [31:0] gap;
    logic seen;
    always @(posedge clock_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            gap <= 32'h0000_0000;
            seen <= 1'b0;
        end else begin
            gap <= refresh_pulse_out ? 32'h0000_0000 : gap + 32'h0000_0001;
            seen <= seen | refresh_pulse_out;
        end
    end
    // first load after reset has no earlier pulse to measure from
    sequence s_load;
        seen && refresh_pulse_out;
    endsequence
    a_rate_good: assert property (
        bit_rate_selector_in inside {[1:8]} |=> bit_rate_valid_out &&
        bit_rate_code_out == $past(bit_rate_selector_in)) else $error("rate");
    a_rate_none: assert property (
        !(bit_rate_selector_in inside {[1:8]}) |=> !bit_rate_valid_out &&
        bit_rate_code_out == 4'h0) else $error("no rate");
    a_station_digits: assert property (
        address_tens_in < 4'ha && address_ones_in < 4'ha |=>
        station_address_out == $past(address_tens_in) * 7'h0a +
        $past(address_ones_in)) else $error("address");
    a_pdo_base: assert property (
        tpdo1_id_out == 11'h180 + station_address_out) else $error("pdo");
    a_image_status: assert property (
        s_load |-> outbound_image_out[23:0] == $past(fieldbus_outputs_in)
        && outbound_image_out[31:29] == {2'b00, $past(link_ok_in)})
        else $error("status");
    a_table_echo: assert property (
        s_load |-> outbound_image_out[39:32] ==
        $past(inbound_image_out[39:32], 2)) else $error("echo");
    a_missing_mark: assert property (
        s_load ##0 $past(inbound_image_out[39:32], 2) inside {8'h02, 8'h06}
        |-> outbound_image_out[47:40] == 8'hff) else $error("missing");
    a_read_byte: assert property (
        read_width_in == 2'h0 && read_byte_in < 5'h14 |=> read_data_out ==
        {24'h00_0000, $past(outbound_image_out[8 * read_byte_in +: 8])})
        else $error("read");
    a_refresh_gap: assert property (
        seen |-> gap <= REFRESH_CYCLES - 1 &&
        (!refresh_pulse_out || gap == REFRESH_CYCLES - 1))
        else $error("gap");
endmodule // fieldbus_image_props

bind fieldbus_process_image_slave fieldbus_image_props #(
    .REFRESH_CYCLES(REFRESH_CYCLES)
) chk (.clock_in, .arst_n_in, .address_tens_in, .address_ones_in,
    .bit_rate_selector_in, .fieldbus_outputs_in, .link_ok_in,
    .read_byte_in, .read_width_in, .read_data_out, .station_address_out,
    .bit_rate_code_out, .bit_rate_valid_out, .outbound_image_out,
    .inbound_image_out, .refresh_pulse_out, .tpdo1_id_out);

//--- tb/fieldbus_master_model.sv
`timescale 1ns/1ps
module fieldbus_master_model (
    // clock and image
    input wire clock_in,
    input wire refresh_in,
    input wire [31:0] read_data_in,
    // requests
    output logic [159:0] inbound_data_out = 160'h0,
    output logic [19:0] inbound_strobe_out = 20'h0_0000,
    output logic [4:0] read_byte_out = 5'h00,
    output logic [1:0] read_width_out = 2'h0
);
    // bounded so a dead refresh cannot hang the run
    task wait_load;
        integer i;
        i = 0;
        @(posedge clock_in);
        while (refresh_in !== 1'b1 && i < 60) begin
            @(posedge clock_in);
            i = i + 1;
        end
    endtask
    // written just after a load, so the next capture sees it whole
    task ask(input [7:0] tab, input [7:0] seg);
        wait_load;
        inbound_data_out[47:32] <= {seg, tab};
        inbound_strobe_out <= 20'h0_0030;
        @(posedge clock_in);
        inbound_strobe_out <= 20'h0_0000;
        inbound_data_out <= ~inbound_data_out;
        wait_load;
    endtask
    task rd(input [4:0] b, input [1:0] w, output [31:0] d);
        @(posedge clock_in);
        read_byte_out <= b;
        read_width_out <= w;
        @(posedge clock_in);
        #1 d = read_data_in;
    endtask
endmodule // fieldbus_master_model

//--- tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clock_in = 1'b0;
    logic arst_n_in = 1'b0;
    logic [3:0] tens = 4'h9;
    logic [3:0] ones = 4'h9;
    logic [3:0] rate = 4'h0;
    logic [23:0] outs = 24'h00_0000;
    logic [5:0] lamps = 6'h00;
    logic [63:0] ins = 64'h0123_4567_89ab_cdef;
    logic we = 1'b0;
    logic [6:0] idx = 7'h00;
    logic [7:0] dat = 8'h00;
    wire [159:0] in_data;
    wire [19:0] in_stb;
    wire [4:0] rbyte;
    wire [1:0] rwid;
    wire [31:0] rdata;
    wire [6:0] addr;
    wire [3:0] code;
    wire valid;
    wire pulse;
    wire [10:0] id [0:5];
    wire [15:0] obj_o;
    wire [15:0] obj_i;
    integer n_fail = 0;
    integer checks_done = 0;
    integer k;
    logic [31:0] d;
    always #2.5 clock_in = ~clock_in;
    fieldbus_process_image_slave #(.REFRESH_CYCLES(20)) uut (
        .clock_in(clock_in), .arst_n_in(arst_n_in),
        .address_tens_in(tens), .address_ones_in(ones),
        .bit_rate_selector_in(rate), .fieldbus_outputs_in(outs),
        .output_fault_lamp_in(lamps[0]), .input_fault_lamp_in(lamps[1]),
        .general_fault_lamp_in(lamps[2]), .diagnostic_lamp_in(lamps[3]),
        .run_lamp_in(lamps[4]), .link_ok_in(lamps[5]),
        .input_states_in(ins), .config_write_in(we),
        .config_index_in(idx), .config_data_in(dat),
        .inbound_data_in(in_data), .inbound_strobe_in(in_stb),
        .read_byte_in(rbyte), .read_width_in(rwid), .read_data_out(rdata),
        .station_address_out(addr), .bit_rate_code_out(code),
        .bit_rate_valid_out(valid), .outbound_image_out(),
        .inbound_image_out(), .refresh_pulse_out(pulse),
        .tpdo1_id_out(id[0]), .tpdo2_id_out(id[1]), .tpdo3_id_out(id[2]),
        .rpdo1_id_out(id[3]), .rpdo2_id_out(id[4]), .rpdo3_id_out(id[5]),
        .outbound_object_out(obj_o), .inbound_object_out(obj_i));
    fieldbus_master_model model (.clock_in(clock_in), .refresh_in(pulse),
        .read_data_in(rdata), .inbound_data_out(in_data),
        .inbound_strobe_out(in_stb), .read_byte_out(rbyte),
        .read_width_out(rwid));
    task chk(input [31:0] got, input [31:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            n_fail = n_fail + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task conclude;
        $display("checks %0d failures %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // top address 99 and every rate digit
    task t_selectors;
        for (k = 0; k < 16; k = k + 1) begin
            @(posedge clock_in);
            rate <= k[3:0];
            repeat (2) @(posedge clock_in);
            #1 chk({valid, code}, (k > 0 && k < 9) ? k + 16 : 0);
        end
        chk(addr, 7'h63);
        chk({id[0], id[1]}, {11'h1e3, 11'h2e3});
        chk({id[2], id[3]}, {11'h223, 11'h263});
        chk({id[4], id[5]}, {11'h363, 11'h2a3});
        chk({obj_o, obj_i}, 32'h2000_2100);
    endtask
    // inputs change right after a load, never inside capture
    task t_status;
        model.wait_load;
        outs <= 24'ha5_c33c;
        lamps <= 6'h35;
        model.wait_load;
        model.rd(5'h00, 2'h2, d);
        chk(d, 32'h35a5_c33c);
        @(posedge clock_in);
        outs <= 24'h5a_3cc3;
        lamps <= 6'h0a;
        model.wait_load;
        model.wait_load;
        model.rd(5'h02, 2'h1, d);
        chk(d, 32'h0000_0a5a);
        model.rd(5'h13, 2'h0, d);
        chk(d, 32'h0000_0000);
        model.rd(5'h14, 2'h3, d);
        chk(d, 32'h0000_0000);
    endtask
    task t_tables;
        for (k = 1; k < 8; k = k + 1) begin
            model.ask(k[7:0], 8'h00);
            model.rd(5'h04, 2'h1, d);
            chk(d, (k == 2 || k > 5) ? k + 16'hff00 : k);
        end
        model.ask(8'h03, 8'h00);
        model.rd(5'h06, 2'h2, d);
        chk(d, ins[31:0]);
        model.ask(8'h05, 8'h19);
        model.rd(5'h04, 2'h1, d);
        chk(d, 32'h0000_ff05);
        @(posedge clock_in);
        we <= 1'b1;
        idx <= 7'h41;
        dat <= 8'h5e;
        @(posedge clock_in);
        we <= 1'b0;
        // last segment asked first, then one past the end
        model.ask(8'h01, 8'h05);
        model.rd(5'h04, 2'h2, d);
        chk(d[23:0], 24'h5e_0501);
        model.ask(8'h01, 8'h06);
        model.rd(5'h04, 2'h1, d);
        chk(d, 32'h0000_ff01);
    endtask
    initial begin
        repeat (12) @(posedge clock_in);
        // edge flops still see reset low; release seen one edge later
        arst_n_in <= 1'b1;
        t_selectors;
        t_status;
        t_tables;
        conclude;
    end
    initial begin
        #50000;
        n_fail = n_fail + 1;
        conclude;
    end
endmodule // testbench
